// file: lvg_bank_regs.svh
// Register layout, reset value and timing constants of the low-voltage I/O bank
`ifndef LVG_BANK_REGS_SVH
`define LVG_BANK_REGS_SVH

`define LVG_CHANNELS 4
`define LVG_REG_W 16
`define LVG_SEL_W 2

`define LVG_DIR_BIT 0
`define LVG_DIN_BIT 1
`define LVG_DOUT_BIT 2
`define LVG_HYS_BIT 3
`define LVG_DBNC_LSB 4
`define LVG_DBNC_MSB 5
`define LVG_EDGE_LSB 6
`define LVG_EDGE_MSB 7
`define LVG_PKE_BIT 8
`define LVG_ODE_BIT 9
`define LVG_DSE_BIT 10
`define LVG_PUE_BIT 11
`define LVG_PUS_LSB 12
`define LVG_PUS_MSB 13
`define LVG_SRE_LSB 14
`define LVG_SRE_MSB 15

`define LVG_CTRL_RESET 16'h3808

`define LVG_CLK_MHZ 250
`define LVG_DBNC_STEP_MS 10
`define LVG_US_PER_MS 1000
`define LVG_DBNC_CNT_W 24

`endif

// file: lvg_pkg.sv
// Types shared by the low-voltage I/O bank
package lvg_pkg;

    typedef enum logic [1:0] {
        LVG_EDGE_NONE,
        LVG_EDGE_FALL,
        LVG_EDGE_RISE,
        LVG_EDGE_BOTH
    } lvg_edge_t;

    typedef enum logic [1:0] {
        LVG_PULL_10K_DOWN,
        LVG_PULL_10K_UP,
        LVG_PULL_100K_DOWN,
        LVG_PULL_100K_UP
    } lvg_pull_t;

endpackage : lvg_pkg

// file: lvg_bank.sv
// Four-channel low-voltage general purpose I/O bank with per-channel control registers
//
// Functional notes
// - Four independent channels, each configured separately
// - One 16-bit control register per channel
// - Direction bit: 0 input, 1 output drives
// - Read-only bit reports sampled pin level
// - Output level bit sets driven pin level
// - Open drain pulls low only, else push-pull
// - Debounce select: none, 10, 20, 30 ms
// - Edge event select: none, fall, rise, both
// - Pull enable connects selected pull resistor
// - Pull select picks strength and direction
`timescale 1ns/100ps
`include "lvg_bank_regs.svh"

module lvg_bank #(
    parameter int CHANNELS = `LVG_CHANNELS,
    parameter int DBNC_STEP_CYC = `LVG_DBNC_STEP_MS * `LVG_US_PER_MS * `LVG_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`LVG_SEL_W-1:0] reg_sel,
    input wire logic [`LVG_REG_W-1:0] reg_wdata,
    output logic [`LVG_REG_W-1:0] reg_rdata,
    input wire logic [CHANNELS-1:0] pad_in,
    output logic [CHANNELS-1:0] pad_out,
    output logic [CHANNELS-1:0] pad_oe,
    output logic [CHANNELS-1:0] pull_en,
    output logic [CHANNELS-1:0] pull_up,
    output logic [CHANNELS-1:0] pull_strong,
    output logic [CHANNELS-1:0] edge_event
);

    localparam int CNT_W = `LVG_DBNC_CNT_W;

    // Refuse parameter values the select width and counter cannot serve
    if (CHANNELS != `LVG_CHANNELS)
    begin : g_bad_channels
        $error("lvg_bank: channel count must match the register select width");
    end
    if (DBNC_STEP_CYC < 1 || (longint'(DBNC_STEP_CYC) * 3) >= (longint'(1) << CNT_W))
    begin : g_bad_step
        $error("lvg_bank: debounce step does not fit the counter");
    end

    logic [`LVG_REG_W-1:0] ctrl_r [CHANNELS];
    logic [`LVG_REG_W-1:0] ctrl_nxt [CHANNELS];
    logic [CHANNELS-1:0] samp_r;
    logic [CHANNELS-1:0] samp_nxt;
    logic [CHANNELS-1:0] deb_r;
    logic [CHANNELS-1:0] deb_nxt;
    logic [CNT_W-1:0] cnt_r [CHANNELS];
    logic [CNT_W-1:0] cnt_nxt [CHANNELS];
    logic [CHANNELS-1:0] pad_out_r;
    logic [CHANNELS-1:0] pad_out_nxt;
    logic [CHANNELS-1:0] pad_oe_r;
    logic [CHANNELS-1:0] pad_oe_nxt;
    logic [CHANNELS-1:0] pull_en_r;
    logic [CHANNELS-1:0] pull_en_nxt;
    logic [CHANNELS-1:0] pull_up_r;
    logic [CHANNELS-1:0] pull_up_nxt;
    logic [CHANNELS-1:0] pull_strong_r;
    logic [CHANNELS-1:0] pull_strong_nxt;
    logic [CHANNELS-1:0] evt_r;
    logic [CHANNELS-1:0] evt_nxt;
    logic [`LVG_REG_W-1:0] rdata_r;
    logic [`LVG_REG_W-1:0] rdata_nxt;

    localparam logic [CNT_W-1:0] STEP1 = CNT_W'(DBNC_STEP_CYC);
    localparam logic [CNT_W-1:0] STEP2 = CNT_W'(2 * DBNC_STEP_CYC);
    localparam logic [CNT_W-1:0] STEP3 = CNT_W'(3 * DBNC_STEP_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi = gi + 1)
        begin : g_chan
            logic dir;
            logic dout;
            logic open_drain_select;
            logic [1:0] dbnc;
            logic [CNT_W-1:0] limit;
            lvg_pkg::lvg_edge_t edge_sel;
            lvg_pkg::lvg_pull_t pull_sel;

            always_comb
            begin
                dir = ctrl_r[gi][`LVG_DIR_BIT];
                dout = ctrl_r[gi][`LVG_DOUT_BIT];
                open_drain_select = ctrl_r[gi][`LVG_ODE_BIT];
                dbnc = ctrl_r[gi][`LVG_DBNC_MSB:`LVG_DBNC_LSB];
                edge_sel = lvg_pkg::lvg_edge_t'(ctrl_r[gi][`LVG_EDGE_MSB:`LVG_EDGE_LSB]);
                pull_sel = lvg_pkg::lvg_pull_t'(ctrl_r[gi][`LVG_PUS_MSB:`LVG_PUS_LSB]);

                // Software write; the input level bit is never stored
                ctrl_nxt[gi] = ctrl_r[gi];
                if (reg_wr_en && (int'(reg_sel) == gi))
                begin
                    ctrl_nxt[gi] = reg_wdata;
                    ctrl_nxt[gi][`LVG_DIN_BIT] = 1'b0;
                end

                samp_nxt[gi] = pad_in[gi];

                case (dbnc)
                    2'h1: limit = STEP1;
                    2'h2: limit = STEP2;
                    2'h3: limit = STEP3;
                    default: limit = {CNT_W{1'b0}};
                endcase

                // Level must stay different for the whole window before it is accepted
                deb_nxt[gi] = deb_r[gi];
                cnt_nxt[gi] = {CNT_W{1'b0}};
                if (dbnc == 2'h0)
                    deb_nxt[gi] = samp_r[gi];
                else if (samp_r[gi] != deb_r[gi])
                begin
                    if (cnt_r[gi] + 1'b1 >= limit)
                        deb_nxt[gi] = samp_r[gi];
                    else
                        cnt_nxt[gi] = cnt_r[gi] + 1'b1;
                end

                case (edge_sel)
                    lvg_pkg::LVG_EDGE_FALL: evt_nxt[gi] = deb_r[gi] & ~deb_nxt[gi];
                    lvg_pkg::LVG_EDGE_RISE: evt_nxt[gi] = ~deb_r[gi] & deb_nxt[gi];
                    lvg_pkg::LVG_EDGE_BOTH: evt_nxt[gi] = deb_r[gi] ^ deb_nxt[gi];
                    default: evt_nxt[gi] = 1'b0;
                endcase

                if (open_drain_select)
                begin
                    pad_out_nxt[gi] = 1'b0;
                    pad_oe_nxt[gi] = dir & ~dout;
                end
                else
                begin
                    pad_out_nxt[gi] = dout;
                    pad_oe_nxt[gi] = dir;
                end

                pull_en_nxt[gi] = ctrl_r[gi][`LVG_PUE_BIT];
                case (pull_sel)
                    lvg_pkg::LVG_PULL_10K_DOWN:
                    begin
                        pull_up_nxt[gi] = 1'b0;
                        pull_strong_nxt[gi] = 1'b1;
                    end
                    lvg_pkg::LVG_PULL_10K_UP:
                    begin
                        pull_up_nxt[gi] = 1'b1;
                        pull_strong_nxt[gi] = 1'b1;
                    end
                    lvg_pkg::LVG_PULL_100K_DOWN:
                    begin
                        pull_up_nxt[gi] = 1'b0;
                        pull_strong_nxt[gi] = 1'b0;
                    end
                    default:
                    begin
                        pull_up_nxt[gi] = 1'b1;
                        pull_strong_nxt[gi] = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    ctrl_r[gi] <= `LVG_CTRL_RESET;
                    cnt_r[gi] <= {CNT_W{1'b0}};
                end
                else
                begin
                    ctrl_r[gi] <= ctrl_nxt[gi];
                    cnt_r[gi] <= cnt_nxt[gi];
                end
            end
        end
    endgenerate

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd_en)
        begin
            rdata_nxt = ctrl_r[reg_sel];
            rdata_nxt[`LVG_DIN_BIT] = samp_r[reg_sel];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            samp_r <= '0;
            deb_r <= '0;
            pad_out_r <= '0;
            pad_oe_r <= '0;
            pull_en_r <= '0;
            pull_up_r <= '0;
            pull_strong_r <= '0;
            evt_r <= '0;
            rdata_r <= '0;
        end
        else
        begin
            samp_r <= samp_nxt;
            deb_r <= deb_nxt;
            pad_out_r <= pad_out_nxt;
            pad_oe_r <= pad_oe_nxt;
            pull_en_r <= pull_en_nxt;
            pull_up_r <= pull_up_nxt;
            pull_strong_r <= pull_strong_nxt;
            evt_r <= evt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign pad_out = pad_out_r;
    assign pad_oe = pad_oe_r;
    assign pull_en = pull_en_r;
    assign pull_up = pull_up_r;
    assign pull_strong = pull_strong_r;
    assign edge_event = evt_r;

endmodule : lvg_bank

// file: lvg_bank_props.sv
// Port assertions for the low-voltage I/O bank
`timescale 1ns/100ps
`include "lvg_bank_regs.svh"
module lvg_bank_props #(parameter int CHANNELS = 4, parameter int DBNC_STEP_CYC = 8) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`LVG_SEL_W-1:0] reg_sel,
    input wire logic [`LVG_REG_W-1:0] reg_wdata,
    input wire logic [`LVG_REG_W-1:0] reg_rdata,
    input wire logic [CHANNELS-1:0] pad_in,
    input wire logic [CHANNELS-1:0] pad_out,
    input wire logic [CHANNELS-1:0] pad_oe,
    input wire logic [CHANNELS-1:0] pull_en,
    input wire logic [CHANNELS-1:0] pull_up,
    input wire logic [CHANNELS-1:0] pull_strong,
    input wire logic [CHANNELS-1:0] edge_event
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [CHANNELS-1:0] pin_q_r;
    logic [31:0] quiet_r;
    logic [31:0] quiet_nxt;
    // Cycles since any pin last changed
    always_comb quiet_nxt = (pad_in == pin_q_r) ? quiet_r + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys)
    begin
        pin_q_r <= pad_in;
        quiet_r <= sys_rst ? 32'h0 : quiet_nxt;
    end
    chk_push_pull_out: assert property (reg_wr_en && !reg_wdata[`LVG_ODE_BIT] |-> ##2
        pad_oe[$past(reg_sel, 2)] == $past(reg_wdata[`LVG_DIR_BIT], 2)
        && pad_out[$past(reg_sel, 2)] == $past(reg_wdata[`LVG_DOUT_BIT], 2)) else $error("push-pull pin wrong");
    chk_open_drain: assert property (reg_wr_en && reg_wdata[`LVG_ODE_BIT] |-> ##2 !pad_out[$past(reg_sel, 2)]
        && pad_oe[$past(reg_sel, 2)] == ($past(reg_wdata[`LVG_DIR_BIT], 2) && !$past(reg_wdata[`LVG_DOUT_BIT], 2)))
        else $error("open-drain pin wrong");
    chk_pull_enable: assert property (reg_wr_en |-> ##2
        pull_en[$past(reg_sel, 2)] == $past(reg_wdata[`LVG_PUE_BIT], 2)) else $error("pull enable wrong");
    chk_pull_select: assert property (reg_wr_en |-> ##2 pull_up[$past(reg_sel, 2)] == $past(reg_wdata[12], 2)
        && pull_strong[$past(reg_sel, 2)] == !$past(reg_wdata[13], 2)) else $error("pull select wrong");
    chk_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata)) else $error("read data moved");
    chk_quiet_pins: assert property (quiet_r > 3 * DBNC_STEP_CYC + 8 |-> edge_event == '0)
        else $error("event without pin change");
    chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> pad_oe == '0 && edge_event == '0)
        else $error("pin driven in reset");
    chk_reset_pull: assert property ($fell(sys_rst) |=> pull_en == '1 && pull_up == '1 && pull_strong == '0)
        else $error("pull reset wrong");
    cover property (edge_event != '0);
    cover property (reg_wr_en && reg_wdata[`LVG_ODE_BIT]);
    cover property (reg_rd_en && reg_wr_en);
endmodule : lvg_bank_props
bind lvg_bank lvg_bank_props #(.CHANNELS(CHANNELS), .DBNC_STEP_CYC(DBNC_STEP_CYC)) u_lvg_bank_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_en(pull_en), .pull_up(pull_up), .pull_strong(pull_strong), .edge_event(edge_event));

// file: lvg_pad_model.sv
// Board side of the four pins: wire level from pad driver, board driver and pulls
`timescale 1ns/100ps
module lvg_pad_model (
    input wire logic [3:0] pad_out,
    input wire logic [3:0] pad_oe,
    input wire logic [3:0] pull_en,
    input wire logic [3:0] pull_up,
    input wire logic [3:0] brd_val,
    input wire logic [3:0] brd_en,
    output logic [3:0] pad_in
);
    logic [3:0] float_r = 4'hA;
    // Undriven, unpulled pins wander every cycle
    always #4 float_r = ~float_r;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & brd_en & brd_val)
        | (~pad_oe & ~brd_en & pull_en & pull_up) | (~pad_oe & ~brd_en & ~pull_en & float_r);
endmodule : lvg_pad_model

// file: lvg_tb.sv
// Self-checking bench for the low-voltage I/O bank
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata, d, got;
    logic [3:0] pad_in, pad_out, pad_oe, pull_en, pull_up, pull_strong, edge_event;
    logic [3:0] brd_val = 4'h0;
    logic [3:0] brd_en = 4'h0;
    logic [1:0] s;
    logic [1:0] ev_ch = 2'h0;
    int num_errors = 0;
    int num_checks = 0;
    int ev_cnt = 0;
    int n;
    int seed = 32'h93eac3d8;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) ev_cnt <= ev_cnt + int'(edge_event[ev_ch]);
    lvg_bank #(.DBNC_STEP_CYC(8)) u_lvg_bank (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en), .pull_up(pull_up), .pull_strong(pull_strong),
        .edge_event(edge_event));
    lvg_pad_model u_lvg_pad_model (.pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en), .pull_up(pull_up),
        .brd_val(brd_val), .brd_en(brd_en), .pad_in(pad_in));
    task wt(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : wt
    task wr(input logic [1:0] a, input logic [15:0] v);
        reg_sel = a;
        reg_wdata = v;
        reg_wr_en = 1'b1;
        wt(1);
        reg_wr_en = 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, output logic [15:0] v);
        reg_sel = a;
        reg_rd_en = 1'b1;
        wt(1);
        reg_rd_en = 1'b0;
        v = reg_rdata;
    endtask : rd
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Level the pin settles to with the board driving b
    function logic exp_pin(input logic [15:0] c, input logic b);
        return (c[0] && !(c[9] && c[2])) ? (c[2] && !c[9]) : b;
    endfunction : exp_pin
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        wt(5);
        sys_rst = 1'b0;
        wt(4);
        for (int i = 0; i < 4; i++)
        begin
            rd(2'(i), got);
            chk("reset_ctrl", 16'h380A, got);
            wt(1);
        end
        brd_en = 4'hF;
        for (int i = 0; i < 24; i++)
        begin
            d = (i == 0) ? 16'h0205 : (i == 1) ? 16'h0201 : 16'($random(seed));
            brd_val = 4'($random(seed));
            s = 2'($random(seed));
            wr(s, d);
            wt(4);
            rd(s, got);
            chk("readback", (d & 16'hFFFD) | {14'h0, exp_pin(d, brd_val[s]), 1'b0}, got);
        end
        ev_ch = 2'h1;
        for (int m = 0; m < 4; m++)
        begin
            wr(2'h1, 16'(m << 6));
            brd_val[1] = 1'b0;
            wt(6);
            n = ev_cnt;
            brd_val[1] = 1'b1;
            wt(6);
            chk("rise_events", 16'(ev_cnt - n), 16'(m >> 1));
            n = ev_cnt;
            brd_val[1] = 1'b0;
            wt(6);
            chk("fall_events", 16'(ev_cnt - n), 16'(m & 1));
        end
        ev_ch = 2'h0;
        for (int k = 1; k < 4; k++)
        begin
            wr(2'h0, 16'((k << 4) | (3 << 6)));
            brd_val[0] = 1'b0;
            wt(40);
            n = ev_cnt;
            brd_val[0] = 1'b1;
            wt(k * 8 - 2);
            brd_val[0] = 1'b0;
            wt(40);
            chk("glitch_events", 16'(ev_cnt - n), 16'h0);
            brd_val[0] = 1'b1;
            wt(k * 8 + 8);
            chk("debounce_events", 16'(ev_cnt - n), 16'h1);
        end
        wr(2'h3, 16'h0001);
        wt(4);
        reg_wdata = 16'h0000;
        reg_wr_en = 1'b1;
        reg_rd_en = 1'b1;
        wt(1);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        chk("read_during_write", 16'h0001, reg_rdata);
        wt(4);
        rd(2'h3, got);
        chk("after_write", {14'h0, brd_val[3], 1'b0}, got);
        sys_rst = 1'b1;
        wt(2);
        sys_rst = 1'b0;
        wt(4);
        rd(2'h2, got);
        chk("rereset_ctrl", 16'h3808 | {14'h0, brd_val[2], 1'b0}, got);
        report_and_stop;
    end
endmodule : tb
